// [rtl/tpc_timer.sv]
// 16-bit timer with interval, pwm output and pulse-width capture
//
// Strobed register access and the address map were decided locally.
`default_nettype none
module tpc_timer (
   input wire logic mclk,                 // 125 MHz system clock
   input wire logic rst,                  // synchronous reset, active high
   input wire tpc_pkg::tpc_bus_t bus,     // register port request
   output logic [15:0] rdata,             // read data, cycle after read strobe
   input wire logic timer_input_pin,      // asynchronous timer input pin
   input wire logic [2:0] cpu_div_n,      // processor clock divider value
   input wire logic cpu_halt,             // processor halted
   output logic timer_output_pin,         // timer output level
   output logic timer_output_oe_n,        // low while the output is driven
   output logic [7:0] port3_dir,          // port 3 direction, 1 = input
   output logic compare_match_request,    // one-cycle compare match pulse
   output logic ext_interrupt_zero        // one-cycle valid edge pulse
);
   logic [7:0] clksel_r, outctl_r, dir_r, edge_r, scs_r;
   logic [2:0] mode_r;
   logic ovf_r, ff_r, ti_edge, sample_tick, count_tick;
   logic [15:0] cmp_r, cap_r, cnt_r;
   logic [7:0] pre_r;
   logic [2:0] cpu_lg;
   logic [5:0] sub_idx, sub_rev;
   logic [8:0] pwm_width;
   logic pwm_extra, pwm_active, match, running, interval, restart_edge;
   logic cap_mode, cap_read, toggle;
   tpc_pkg::tpc_mode_t mode;

   // request on the register port at a given address
   function automatic logic hit(input tpc_pkg::tpc_bus_t b, input logic [3:0] a, input logic w);
      return (w ? b.wr : b.rd) && b.addr == a;
   endfunction

   // prescaler tap for a division by two to the power lg
   function automatic logic div_tick(input logic [7:0] pre, input logic [2:0] lg);
      logic [7:0] mask;
      mask = 8'((9'h001 << lg) - 9'h001);
      return (pre & mask) == mask;
   endfunction

   assign mode = tpc_pkg::tpc_mode_t'(mode_r);
   assign running = mode != tpc_pkg::TPC_STOP;
   assign interval = mode == tpc_pkg::TPC_INTERVAL || mode == tpc_pkg::TPC_INTERVAL_T;
   assign restart_edge = ti_edge && (mode == tpc_pkg::TPC_RESTART || mode == tpc_pkg::TPC_RESTART_T);
   assign cap_mode = mode == tpc_pkg::TPC_FREE || mode == tpc_pkg::TPC_FREE_T || restart_edge;
   assign cap_read = hit(bus, tpc_pkg::ADR_CAPTURE, 1'b0);
   assign match = cnt_r == cmp_r;

   // software-written control registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         clksel_r <= tpc_pkg::RST_CLOCK_SEL;
         mode_r <= tpc_pkg::RST_MODE;
         outctl_r <= tpc_pkg::RST_OUTCTL;
         dir_r <= tpc_pkg::RST_PORT3_DIR;
         edge_r <= tpc_pkg::RST_EDGE_MODE;
         scs_r <= tpc_pkg::RST_SAMPLE_CLK;
         cmp_r <= tpc_pkg::RST_WORD;
      end else begin
         if (hit(bus, tpc_pkg::ADR_CLOCK_SEL, 1'b1)) clksel_r <= bus.wdata[7:0];
         if (hit(bus, tpc_pkg::ADR_MODE, 1'b1)) mode_r <= bus.wdata[tpc_pkg::MODE_LSB +: 3];
         // strobe bits are not stored, so they read back as zero
         if (hit(bus, tpc_pkg::ADR_OUTCTL, 1'b1)) outctl_r <= {6'h00, bus.wdata[1:0]};
         if (hit(bus, tpc_pkg::ADR_PORT3_DIR, 1'b1)) dir_r <= bus.wdata[7:0];
         if (hit(bus, tpc_pkg::ADR_EDGE_MODE, 1'b1)) edge_r <= bus.wdata[7:0];
         if (hit(bus, tpc_pkg::ADR_SAMPLE_CLK, 1'b1)) scs_r <= bus.wdata[7:0];
         if (hit(bus, tpc_pkg::ADR_COMPARE, 1'b1)) cmp_r <= bus.wdata;
      end
   end

   // free-running prescaler for count and sampling clocks
   always_ff @(posedge mclk) begin
      if (rst) pre_r <= 8'h00;
      else pre_r <= pre_r + 8'h01;
   end

   // sampling clock choice; the processor choice stops in halt
   always_comb begin
      cpu_lg = (cpu_div_n > tpc_pkg::CPU_N_MAX) ? 3'h5 : 3'(cpu_div_n + 3'h1);
      case (tpc_pkg::tpc_ssel_t'(scs_r[1:0]))
         tpc_pkg::SC_CPU: sample_tick = !cpu_halt && div_tick(pre_r, cpu_lg);
         tpc_pkg::SC_DIV_A: sample_tick = div_tick(pre_r, tpc_pkg::LG_SAMP_A);
         tpc_pkg::SC_DIV_B: sample_tick = div_tick(pre_r, tpc_pkg::LG_SAMP_B);
         default: sample_tick = 1'b0;
      endcase
   end

   // count clock choice; prohibited codes do not count
   always_comb begin
      case (tpc_pkg::tpc_csel_t'(clksel_r[tpc_pkg::CSEL_LSB +: 3]))
         tpc_pkg::CS_EXT: count_tick = ti_edge;
         tpc_pkg::CS_DIV1: count_tick = div_tick(pre_r, tpc_pkg::LG_DIV1);
         tpc_pkg::CS_DIV2: count_tick = div_tick(pre_r, tpc_pkg::LG_DIV2);
         tpc_pkg::CS_DIV4: count_tick = div_tick(pre_r, tpc_pkg::LG_DIV4);
         tpc_pkg::CS_DIV8: count_tick = div_tick(pre_r, tpc_pkg::LG_DIV8);
         default: count_tick = 1'b0;
      endcase
   end

   // filtered valid edge on the timer input
   tpc_edge_filter u_filter (
      .mclk(mclk),
      .rst(rst),
      .pin_raw(timer_input_pin),
      .sample_tick(sample_tick),
      .edge_sel(edge_r[tpc_pkg::ES_LSB +: 2]),
      .valid_edge(ti_edge)
   );

   // up counter
   always_ff @(posedge mclk) begin
      if (rst || !running) cnt_r <= 16'h0000;
      else if (restart_edge) cnt_r <= 16'h0000;
      else if (count_tick && match && interval) cnt_r <= 16'h0000;
      else if (count_tick) cnt_r <= cnt_r + 16'h0001;
   end

   // overflow flag; a set beats a software clear
   always_ff @(posedge mclk) begin
      if (rst) ovf_r <= 1'b0;
      else if (running && count_tick && !restart_edge && cnt_r == 16'hFFFF && !(interval && match)) ovf_r <= 1'b1;
      else if (hit(bus, tpc_pkg::ADR_MODE, 1'b1) && !bus.wdata[tpc_pkg::OVF_BIT]) ovf_r <= 1'b0;
   end

   // compare match and external edge requests
   always_ff @(posedge mclk) begin
      if (rst) begin
         compare_match_request <= 1'b0;
         ext_interrupt_zero <= 1'b0;
      end else begin
         compare_match_request <= running && count_tick && match;
         ext_interrupt_zero <= ti_edge;
      end
   end

   // capture register, held while software reads it
   always_ff @(posedge mclk) begin
      if (rst) cap_r <= 16'h0000;
      else if (ti_edge && cap_mode && !cap_read) cap_r <= cnt_r;
   end

   // output flip-flop: software strobes, toggle on match or edge
   assign toggle = outctl_r[tpc_pkg::OC_LVL_BIT] && running && mode != tpc_pkg::TPC_PWM
      && ((count_tick && match) || (mode_r[0] && ti_edge));
   always_ff @(posedge mclk) begin
      if (rst) ff_r <= 1'b0;
      else if (hit(bus, tpc_pkg::ADR_OUTCTL, 1'b1) && bus.wdata[tpc_pkg::OC_SET_BIT]) ff_r <= 1'b1;
      else if (hit(bus, tpc_pkg::ADR_OUTCTL, 1'b1) && bus.wdata[tpc_pkg::OC_RST_BIT]) ff_r <= 1'b0;
      else if (toggle) ff_r <= !ff_r;
   end

   // pwm: 256-count basic cycle, 64 basic cycles per sub-cycle
   assign sub_idx = cnt_r[13:8];
   for (genvar i = 0; i < 6; i++) begin : g_rev
      assign sub_rev[i] = sub_idx[5 - i];
   end
   assign pwm_extra = sub_rev < cmp_r[7:2];
   assign pwm_width = {1'b0, cmp_r[15:8]} + {8'h00, pwm_extra};
   assign pwm_active = {1'b0, cnt_r[7:0]} < pwm_width;

   // timer output pin
   always_ff @(posedge mclk) begin
      if (rst) timer_output_pin <= 1'b0;
      else begin
         case (mode)
            tpc_pkg::TPC_PWM: timer_output_pin <= outctl_r[tpc_pkg::OC_EN_BIT]
               && (pwm_active ^ outctl_r[tpc_pkg::OC_LVL_BIT]);
            default: timer_output_pin <= outctl_r[tpc_pkg::OC_EN_BIT] && ff_r;
         endcase
      end
   end
   assign timer_output_oe_n = dir_r[tpc_pkg::DIR_TIMER_BIT];
   assign port3_dir = dir_r;

   // registered read data, present only in the cycle after a read
   always_ff @(posedge mclk) begin
      if (rst || !bus.rd) rdata <= 16'h0000;
      else begin
         case (bus.addr)
            tpc_pkg::ADR_CLOCK_SEL: rdata <= {8'h00, clksel_r};
            tpc_pkg::ADR_MODE: rdata <= {12'h000, mode_r, ovf_r};
            tpc_pkg::ADR_OUTCTL: rdata <= {8'h00, outctl_r};
            tpc_pkg::ADR_PORT3_DIR: rdata <= {8'h00, dir_r};
            tpc_pkg::ADR_EDGE_MODE: rdata <= {8'h00, edge_r};
            tpc_pkg::ADR_SAMPLE_CLK: rdata <= {8'h00, scs_r};
            tpc_pkg::ADR_COMPARE: rdata <= cmp_r;
            tpc_pkg::ADR_CAPTURE: rdata <= cap_r;
            tpc_pkg::ADR_COUNTER: rdata <= cnt_r;
            default: rdata <= 16'h0000;
         endcase
      end
   end

   // checks
   AST_OUTCTL_RESET: assert property (@(posedge mclk) rst |=> outctl_r == 8'h00)
      else $error("output control not cleared by reset");
   AST_STROBE_READ_ZERO: assert property (@(posedge mclk) disable iff (rst)
      (bus.rd && bus.addr == tpc_pkg::ADR_OUTCTL) |=> rdata[3:2] == 2'b00)
      else $error("strobe bits read nonzero");
   AST_DIR_RESET: assert property (@(posedge mclk) rst |=> port3_dir == 8'hFF && timer_output_oe_n)
      else $error("port 3 direction not all inputs after reset");
   AST_EDGE_SCS_RESET: assert property (@(posedge mclk) rst |=> edge_r == 8'h00 && scs_r == 8'h00)
      else $error("edge mode or sampling clock not cleared by reset");
   AST_HALT_NO_SAMPLE: assert property (@(posedge mclk) disable iff (rst)
      (cpu_halt && scs_r[1:0] == 2'b00) |-> !sample_tick)
      else $error("processor sampling clock ran during halt");
   AST_INTERVAL_CLEAR: assert property (@(posedge mclk) disable iff (rst)
      (interval && count_tick && match && !restart_edge) |=> cnt_r == 16'h0000 && compare_match_request)
      else $error("interval match did not clear counter and request");
   AST_STOP_CLEAR: assert property (@(posedge mclk) disable iff (rst)
      (mode_r == 3'b000) [*2] |-> cnt_r == 16'h0000 && !compare_match_request)
      else $error("stopped counter not held at zero");
   AST_DIV8_GAP: assert property (@(posedge mclk) disable iff (rst)
      (clksel_r[6:4] == 3'b100 && count_tick) |=> (!count_tick || clksel_r[6:4] != 3'b100) [*7])
      else $error("divide by eight count clock too fast");
   AST_CAPTURE: assert property (@(posedge mclk) disable iff (rst)
      (ti_edge && mode == tpc_pkg::TPC_FREE && !cap_read) |=> cap_r == $past(cnt_r) && ext_interrupt_zero)
      else $error("free-running capture missed");
   AST_READ_HOLDS: assert property (@(posedge mclk) disable iff (rst)
      (ti_edge && cap_read) |=> $stable(cap_r) && ext_interrupt_zero)
      else $error("capture changed during read or request lost");
   AST_RESTART: assert property (@(posedge mclk) disable iff (rst)
      (restart_edge && !cap_read) |=> cnt_r == 16'h0000 && cap_r == $past(cnt_r))
      else $error("restart edge did not capture and clear");
   AST_PWM_DISABLED: assert property (@(posedge mclk) disable iff (rst)
      (mode == tpc_pkg::TPC_PWM && !outctl_r[0]) |=> !timer_output_pin)
      else $error("pwm output active while disabled");
endmodule
`default_nettype wire

// [pkg/tpc_pkg.sv]
// constants, types and register map of the 16-bit timer with pwm and capture
`default_nettype none
package tpc_pkg;
   // register word addresses on the register port
   localparam logic [3:0] ADR_CLOCK_SEL = 4'h0;
   localparam logic [3:0] ADR_MODE = 4'h1;
   localparam logic [3:0] ADR_OUTCTL = 4'h2;
   localparam logic [3:0] ADR_PORT3_DIR = 4'h3;
   localparam logic [3:0] ADR_EDGE_MODE = 4'h4;
   localparam logic [3:0] ADR_SAMPLE_CLK = 4'h5;
   localparam logic [3:0] ADR_COMPARE = 4'h6;
   localparam logic [3:0] ADR_CAPTURE = 4'h7;
   localparam logic [3:0] ADR_COUNTER = 4'h8;

   // values after reset
   localparam logic [7:0] RST_CLOCK_SEL = 8'h00;
   localparam logic [2:0] RST_MODE = 3'h0;
   localparam logic [7:0] RST_OUTCTL = 8'h00;
   localparam logic [7:0] RST_PORT3_DIR = 8'hFF;
   localparam logic [7:0] RST_EDGE_MODE = 8'h00;
   localparam logic [7:0] RST_SAMPLE_CLK = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;

   // field positions
   localparam int OC_EN_BIT = 0;
   localparam int OC_LVL_BIT = 1;
   localparam int OC_RST_BIT = 2;
   localparam int OC_SET_BIT = 3;
   localparam int MODE_LSB = 1;
   localparam int OVF_BIT = 0;
   localparam int CSEL_LSB = 4;
   localparam int ES_LSB = 2;
   localparam int DIR_TIMER_BIT = 0;

   // divider exponents (count clock and sampling clock)
   localparam logic [2:0] LG_DIV1 = 3'h0;
   localparam logic [2:0] LG_DIV2 = 3'h1;
   localparam logic [2:0] LG_DIV4 = 3'h2;
   localparam logic [2:0] LG_DIV8 = 3'h3;
   localparam logic [2:0] LG_SAMP_A = 3'h6;
   localparam logic [2:0] LG_SAMP_B = 3'h7;
   localparam logic [2:0] CPU_N_MAX = 3'h4;
   localparam int DIV8_GAP = 7;

   typedef enum logic [2:0] {
      TPC_STOP = 3'b000,
      TPC_PWM = 3'b001,
      TPC_FREE = 3'b010,
      TPC_FREE_T = 3'b011,
      TPC_RESTART = 3'b100,
      TPC_RESTART_T = 3'b101,
      TPC_INTERVAL = 3'b110,
      TPC_INTERVAL_T = 3'b111
   } tpc_mode_t;

   typedef enum logic [2:0] {
      CS_EXT = 3'b000,
      CS_DIV1 = 3'b001,
      CS_DIV2 = 3'b010,
      CS_DIV4 = 3'b011,
      CS_DIV8 = 3'b100
   } tpc_csel_t;

   typedef enum logic [1:0] {
      ES_FALL = 2'b00,
      ES_RISE = 2'b01,
      ES_NONE = 2'b10,
      ES_BOTH = 2'b11
   } tpc_esel_t;

   typedef enum logic [1:0] {
      SC_CPU = 2'b00,
      SC_DIV_A = 2'b01,
      SC_DIV_B = 2'b10
   } tpc_ssel_t;

   // one request on the register port
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } tpc_bus_t;
endpackage
`default_nettype wire

// [rtl/tpc_edge_filter.sv]
// synchroniser, sampled two-sample noise filter and valid-edge selector
`default_nettype none
module tpc_edge_filter (
   input wire logic mclk,        // system clock
   input wire logic rst,         // synchronous reset, active high
   input wire logic pin_raw,     // asynchronous timer input pin
   input wire logic sample_tick, // one-cycle sampling strobe
   input wire logic [1:0] edge_sel, // valid edge choice
   output logic valid_edge       // one-cycle pulse per accepted edge
);
   logic sync1_r, sync2_r, samp_r, level_r;

   // two flip-flops before any logic sees the pin
   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= pin_raw;
         sync2_r <= sync1_r;
      end
   end

   // a new level counts only when two successive samples agree
   always_ff @(posedge mclk) begin
      if (rst) begin
         samp_r <= 1'b0;
         level_r <= 1'b0;
         valid_edge <= 1'b0;
      end else begin
         valid_edge <= 1'b0;
         if (sample_tick) begin
            samp_r <= sync2_r;
            if (sync2_r == samp_r && sync2_r != level_r) begin
               level_r <= sync2_r;
               case (tpc_pkg::tpc_esel_t'(edge_sel))
                  tpc_pkg::ES_FALL: valid_edge <= !sync2_r;
                  tpc_pkg::ES_RISE: valid_edge <= sync2_r;
                  tpc_pkg::ES_BOTH: valid_edge <= 1'b1;
                  default: valid_edge <= 1'b0;
               endcase
            end
         end
      end
   end
endmodule
`default_nettype wire

// [verification/tpc_pulse_load.sv]
// pulse source on the timer input and integrating load on the timer output
`default_nettype none
module tpc_pulse_load (
   input wire logic mclk,  // system clock
   output logic ti_pin,    // driven timer input level
   input wire logic to_pin // observed timer output level
);
   timeunit 1ns;
   timeprecision 1ps;
   // the source idles low and drives actively at all times
   initial ti_pin = 1'b0;
   // one high pulse of the given width in clock cycles, changed after an edge
   task automatic pulse(input int width);
      @(posedge mclk);
      ti_pin <= 1'b1;
      repeat (width) @(posedge mclk);
      ti_pin <= 1'b0;
   endtask
   // count high output cycles over a window, as a low-pass load averages them
   task automatic measure(input int n, output int high);
      high = 0;
      repeat (n) begin
         @(posedge mclk);
         #1 if (to_pin === 1'b1) high++;
      end
   endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench of the timer with a register model and pulse partner
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst, cpu_halt, ti_pin, to_pin, to_oe_n, cmr, ext_int;
   logic [2:0] cpu_div_n;
   logic [15:0] rdata;
   logic [7:0] port3_dir;
   tpc_pkg::tpc_bus_t bus;
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_int = 0;
   int mdl [16];
   int match_q [$];
   tpc_timer u_tpc_timer (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .timer_input_pin(ti_pin),
      .cpu_div_n(cpu_div_n), .cpu_halt(cpu_halt), .timer_output_pin(to_pin), .timer_output_oe_n(to_oe_n),
      .port3_dir(port3_dir), .compare_match_request(cmr), .ext_interrupt_zero(ext_int));
   tpc_pulse_load u_tpc_pulse_load (.mclk(mclk), .ti_pin(ti_pin), .to_pin(to_pin));
   // 125 MHz clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // cycle count, event log and hang cut-off
   always @(posedge mclk) begin
      cyc++;
      if (cmr === 1'b1) match_q.push_back(cyc);
      if (ext_int === 1'b1) n_int++;
      if (cyc == 80000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask
   // one-cycle write; the model keeps what a read should return
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      mdl[a] = (a == tpc_pkg::ADR_OUTCTL) ? int'(d & 16'h0003) : int'(d);
      @(posedge mclk);
      bus <= '{default: '0};
   endtask
   // one-cycle read; data stand only in the following cycle
   task automatic rdchk(input logic [3:0] a, input string what);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus <= '{default: '0};
      #1 chk(what, 16'(mdl[a]), rdata);
   endtask
   task automatic wait_matches(input int n);
      int lim;
      lim = 0;
      while (match_q.size() < n && lim < 5000) begin
         @(posedge mclk);
         lim++;
      end
   endtask
   initial begin
      logic [15:0] d, cmp, w;
      int hi, exp_hi;
      void'($urandom(32'h6527));
      rst = 1'b1;
      cpu_halt = 1'b0;
      cpu_div_n = 3'h0;
      bus = '{default: '0};
      mdl = '{default: 0};
      mdl[tpc_pkg::ADR_PORT3_DIR] = 32'h0000_00FF;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      // reset values, strobes, direction register and an unmapped place
      rdchk(tpc_pkg::ADR_OUTCTL, "outctl reset");
      rdchk(tpc_pkg::ADR_PORT3_DIR, "port3 reset");
      rdchk(tpc_pkg::ADR_EDGE_MODE, "edge mode reset");
      rdchk(tpc_pkg::ADR_SAMPLE_CLK, "sample clock reset");
      chk("port3 pins", 16'h00FF, {8'h00, port3_dir});
      chk("oe_n released", 16'h0001, {15'h0000, to_oe_n});
      rdchk(4'hF, "unmapped");
      wr(tpc_pkg::ADR_OUTCTL, 16'h000E);
      rdchk(tpc_pkg::ADR_OUTCTL, "strobes read zero");
      wr(tpc_pkg::ADR_PORT3_DIR, {8'h00, 8'($urandom)});
      rdchk(tpc_pkg::ADR_PORT3_DIR, "port3 rw");
      wr(tpc_pkg::ADR_PORT3_DIR, 16'h00FE);
      #1 chk("oe_n driven", 16'h0000, {15'h0000, to_oe_n});
      // interval period for every count clock divider
      for (int cs = 1; cs <= 4; cs++) begin
         cmp = 16'(1 + $urandom % 20);
         wr(tpc_pkg::ADR_CLOCK_SEL, 16'(cs << 4));
         wr(tpc_pkg::ADR_COMPARE, cmp);
         rdchk(tpc_pkg::ADR_COMPARE, "compare rw");
         wr(tpc_pkg::ADR_MODE, 16'h000C);
         match_q.delete();
         wait_matches(3);
         chk("interval", 16'((cmp + 1) << (cs - 1)), match_q.size() >= 3 ? 16'(match_q[2] - match_q[1]) : 16'hFFFF);
         wr(tpc_pkg::ADR_MODE, 16'h0000);
         rdchk(tpc_pkg::ADR_COUNTER, "counter stopped");
      end
      // valid edge choice and restart capture, widths a whole number of samples
      wr(tpc_pkg::ADR_CLOCK_SEL, 16'h0010);
      wr(tpc_pkg::ADR_SAMPLE_CLK, 16'h0000);
      for (int es = 0; es < 4; es++) begin
         w = 16'(32 * (2 + $urandom % 4));
         cpu_div_n <= 3'($urandom % 5);
         wr(tpc_pkg::ADR_MODE, 16'h0000);
         wr(tpc_pkg::ADR_EDGE_MODE, 16'(es << 2));
         rdchk(tpc_pkg::ADR_EDGE_MODE, "edge mode rw");
         wr(tpc_pkg::ADR_MODE, es == 1 ? 16'h0004 : 16'h0008);
         n_int = 0;
         u_tpc_pulse_load.pulse(int'(w));
         repeat (150) @(posedge mclk);
         chk("edge count", es < 2 ? 16'h0001 : (es == 3 ? 16'h0002 : 16'h0000), 16'(n_int));
         if (es == 3) begin
            mdl[tpc_pkg::ADR_CAPTURE] = int'(w) - 1;
            rdchk(tpc_pkg::ADR_CAPTURE, "pulse width");
         end
      end
      // a glitch seen by one sample only is rejected
      cpu_div_n <= 3'h4;
      wr(tpc_pkg::ADR_SAMPLE_CLK, 16'h0001);
      n_int = 0;
      u_tpc_pulse_load.pulse(1);
      repeat (100) @(posedge mclk);
      chk("glitch", 16'h0000, 16'(n_int));
      wr(tpc_pkg::ADR_SAMPLE_CLK, 16'h0000);
      // edges during a long capture read keep the old capture
      @(posedge mclk);
      bus <= '{addr: tpc_pkg::ADR_CAPTURE, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      fork
         u_tpc_pulse_load.pulse(64);
         repeat (200) begin
            @(posedge mclk);
            #1 chk("held capture", 16'(mdl[tpc_pkg::ADR_CAPTURE]), rdata);
         end
      join
      bus <= '{default: '0};
      chk("edges in read", 16'h0002, 16'(n_int));
      // processor sampling clock stands while halted
      cpu_halt <= 1'b1;
      n_int = 0;
      u_tpc_pulse_load.pulse(64);
      repeat (150) @(posedge mclk);
      chk("halted sampling", 16'h0000, 16'(n_int));
      cpu_halt <= 1'b0;
      // pwm duty over a full sub-cycle: active high, active low, disabled
      d = 16'($urandom % 16384);
      for (int k = 0; k < 3; k++) begin
         wr(tpc_pkg::ADR_MODE, 16'h0000);
         wr(tpc_pkg::ADR_OUTCTL, k == 2 ? 16'h0000 : 16'(1 + 2 * k));
         wr(tpc_pkg::ADR_MODE, 16'h0002);
         wr(tpc_pkg::ADR_COMPARE, {d[13:0], 2'b00});
         repeat (4) @(posedge mclk);
         u_tpc_pulse_load.measure(16384, hi);
         exp_hi = k == 0 ? int'(d) : (k == 1 ? 16384 - int'(d) : 0);
         chk("pwm high cycles", 16'(exp_hi), 16'(hi));
      end
      wrap_up();
   end
endmodule
`default_nettype wire
